// *** rtl/sxte_consts.vh ***
// constants for the swap / xor / direction-load execution block
`ifndef SXTE_CONSTS_VH
`define SXTE_CONSTS_VH
`define SXTE_OPC_W 14
`define SXTE_DATA_W 8
`define SXTE_ADDR_W 7
`define SXTE_NUM_FILE 128
`define SXTE_OP6_SWAP 6'h0e
`define SXTE_OP6_XORF 6'h06
`define SXTE_OP6_XORL 6'h3a
`define SXTE_DIRL_HI 11'h00c
`define SXTE_DIR_FIRST 3'h5
`define SXTE_DIR_LAST 3'h7
`define SXTE_DEST_BIT 7
`define SXTE_W_RESET 8'h00
`define SXTE_Z_RESET 1'b0
`define SXTE_DIR_RESET 8'hff
`endif

// *** rtl/sxte_file_mem.v ***
// file register memory, registered read data
`timescale 1ns/10ps
`default_nettype none
`include "sxte_consts.vh"
module sxte_file_mem (
  input wire ref_clk_i,                       // core clock
  input wire [`SXTE_ADDR_W-1:0] rd_addr_i,    // read address
  output reg [`SXTE_DATA_W-1:0] rd_data_o,    // read data, one cycle later
  input wire wr_en_i,                         // write strobe
  input wire [`SXTE_ADDR_W-1:0] wr_addr_i,    // write address
  input wire [`SXTE_DATA_W-1:0] wr_data_i     // write data
);
  reg [`SXTE_DATA_W-1:0] mem [0:`SXTE_NUM_FILE-1];

  // write-first so a back-to-back read sees fresh data
  always @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    if (wr_en_i && wr_addr_i == rd_addr_i) begin
      rd_data_o <= wr_data_i;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule // sxte_file_mem
`default_nettype wire

// *** rtl/sxte_exec.v ***
// execution of swap, xor and legacy direction-load opcodes
`timescale 1ns/10ps
`default_nettype none
`include "sxte_consts.vh"
// What this block does
// - nibble_swap_op exchanges the file register nibbles, no flag change.
// - nibble_swap_op: d=0 writes acc, d=1 writes the file register.
// - xor_literal_op: acc xor literal into acc, zero flag only.
// - direction_load_op: acc into direction register 5..7, no flag change.
// - xor_file_op: acc xor file register to dest d, zero flag only.
module sxte_exec (
  input wire ref_clk_i,                          // core clock, 250 MHz
  input wire reset_n_i,                          // sync reset, active low
  input wire opc_valid_i,                        // opcode strobe
  input wire [`SXTE_OPC_W-1:0] opc_i,            // 14-bit opcode
  output wire busy_o,                            // execute phase in progress
  output reg done_o,                             // one-cycle completion pulse
  output reg [`SXTE_DATA_W-1:0] acc_o,           // accumulator
  output reg zero_o,                             // zero flag
  output reg [`SXTE_DATA_W-1:0] dir5_o,          // direction register 5
  output reg [`SXTE_DATA_W-1:0] dir6_o,          // direction register 6
  output reg [`SXTE_DATA_W-1:0] dir7_o,          // direction register 7
  input wire dbg_rd_valid_i,                     // direct read of a file reg
  input wire [`SXTE_ADDR_W-1:0] dbg_addr_i,      // direct read address
  output wire [`SXTE_DATA_W-1:0] dbg_data_o      // file memory read data
);
  localparam ST_IDLE = 1'b0;
  localparam ST_EXEC = 1'b1;

  // op classes, decoded once on accept
  localparam K_NONE = 3'h0;
  localparam K_SWAP = 3'h1;
  localparam K_XORF = 3'h2;
  localparam K_XORL = 3'h3;
  localparam K_DIRL = 3'h4;

  function [2:0] op_kind;
    input [`SXTE_OPC_W-1:0] op;
    begin
      if (op[13:8] == `SXTE_OP6_SWAP) op_kind = K_SWAP;
      else if (op[13:8] == `SXTE_OP6_XORF) op_kind = K_XORF;
      else if (op[13:8] == `SXTE_OP6_XORL) op_kind = K_XORL;
      else if (op[13:3] == `SXTE_DIRL_HI && op[2:0] >= `SXTE_DIR_FIRST)
        op_kind = K_DIRL;
      else op_kind = K_NONE;
    end
  endfunction

  function [`SXTE_DATA_W-1:0] swap_nib;
    input [`SXTE_DATA_W-1:0] v;
    begin
      swap_nib = {v[3:0], v[7:4]};
    end
  endfunction

  // shared by both xor paths
  function is_zero;
    input [`SXTE_DATA_W-1:0] v;
    begin
      is_zero = (v == {`SXTE_DATA_W{1'b0}});
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  reg state_r;
  reg [2:0] kind_r;
  reg [`SXTE_OPC_W-1:0] opc_r;
  reg [2:0] kind_now;
  wire [`SXTE_DATA_W-1:0] file_q;
  reg [`SXTE_ADDR_W-1:0] rd_addr;
  reg [`SXTE_DATA_W-1:0] result;
  reg wr_file;
  wire to_file;
  // next values of the registers
  reg state_nxt;
  reg [2:0] kind_nxt;
  reg [`SXTE_OPC_W-1:0] opc_nxt;
  reg done_nxt;
  reg [`SXTE_DATA_W-1:0] acc_nxt;
  reg zero_nxt;
  reg [`SXTE_DATA_W-1:0] dir5_nxt;
  reg [`SXTE_DATA_W-1:0] dir6_nxt;
  reg [`SXTE_DATA_W-1:0] dir7_nxt;
  wire accept;

  always @* begin
    kind_now = op_kind(opc_i);
  end

  // file read issued on accept so data are ready in the execute cycle;
  // with no debug read the last operand stays on the read port
  always @* begin
    if (accept) begin
      rd_addr = opc_i[`SXTE_ADDR_W-1:0];
    end else if (dbg_rd_valid_i) begin
      rd_addr = dbg_addr_i;
    end else begin
      rd_addr = opc_r[`SXTE_ADDR_W-1:0];
    end
  end
  // a strobe seen while busy is refused: only idle takes
  assign accept = (state_r == ST_IDLE) && opc_valid_i;
  assign busy_o = (state_r == ST_EXEC);
  assign dbg_data_o = file_q;
  assign to_file = opc_r[`SXTE_DEST_BIT];

  // write port always follows the latched operand address
  sxte_file_mem u_mem (
    .ref_clk_i(ref_clk_i),
    .rd_addr_i(rd_addr),
    .rd_data_o(file_q),
    .wr_en_i(wr_file),
    .wr_addr_i(opc_r[`SXTE_ADDR_W-1:0]),
    .wr_data_i(result)
  );

  ////////////////////////////////////////////////////////////////////////
  always @* begin
    result = acc_o;
    wr_file = 1'b0;
    if (state_r == ST_EXEC) begin
      case (kind_r)
        K_SWAP: begin
          result = swap_nib(file_q);
          wr_file = to_file;
        end
        K_XORF: begin
          result = acc_o ^ file_q;
          wr_file = to_file;
        end
        K_XORL: result = acc_o ^ opc_r[7:0];
        default: result = acc_o;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-cycle issue: the operand read takes the edge before the execute
  // edge, traded against the bypass that one-cycle issue would need
  always @* begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    opc_nxt = opc_r;
    done_nxt = 1'b0;
    acc_nxt = acc_o;
    zero_nxt = zero_o;
    dir5_nxt = dir5_o;
    dir6_nxt = dir6_o;
    dir7_nxt = dir7_o;
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          opc_nxt = opc_i;
          kind_nxt = kind_now;
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_nxt = ST_IDLE;
        done_nxt = 1'b1;
        case (kind_r)
          K_SWAP: begin
            if (!to_file) acc_nxt = result;
          end
          K_XORF: begin
            if (!to_file) acc_nxt = result;
            zero_nxt = is_zero(result);
          end
          K_XORL: begin
            acc_nxt = result;
            zero_nxt = is_zero(result);
          end
          K_DIRL: begin
            case (opc_r[2:0])
              3'h5: dir5_nxt = acc_o;
              3'h6: dir6_nxt = acc_o;
              3'h7: dir7_nxt = acc_o;
              default: dir7_nxt = dir7_o;
            endcase
          end
          default: acc_nxt = acc_o;
        endcase
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencing; unknown opcodes complete without side effects
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
      kind_r <= K_NONE;
      opc_r <= {`SXTE_OPC_W{1'b0}};
      done_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      opc_r <= opc_nxt;
      done_o <= done_nxt;
    end
  end

  // architectural state: accumulator, zero flag, direction registers
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      acc_o <= `SXTE_W_RESET;
      zero_o <= `SXTE_Z_RESET;
      dir5_o <= `SXTE_DIR_RESET;
      dir6_o <= `SXTE_DIR_RESET;
      dir7_o <= `SXTE_DIR_RESET;
    end else begin
      acc_o <= acc_nxt;
      zero_o <= zero_nxt;
      dir5_o <= dir5_nxt;
      dir6_o <= dir6_nxt;
      dir7_o <= dir7_nxt;
    end
  end
endmodule // sxte_exec
`default_nettype wire

// *** test/sxte_exec_monitor.sv ***
// checker for the swap / xor / direction-load execution block
`timescale 1ns/10ps
`default_nettype none
module sxte_exec_chk (
  input wire logic ref_clk_i,        // core clock
  input wire logic reset_n_i,        // sync reset, active low
  input wire logic opc_valid_i,      // opcode strobe
  input wire logic [13:0] opc_i,     // opcode
  input wire logic busy_o,           // execute cycle
  input wire logic done_o,           // completion pulse
  input wire logic [7:0] acc_o,      // accumulator
  input wire logic zero_o,           // zero flag
  input wire logic [7:0] dir5_o      // direction register 5
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic tk;
  logic [5:0] op6;
  assign tk = opc_valid_i && !busy_o;
  assign op6 = opc_i[13:8];
  AST_DONE: assert property (tk |=> busy_o ##1 (done_o && !busy_o))
    else $error("completion pulse late or missing");
  AST_SWAP_FLAG: assert property (tk && op6 == 6'h0e
    |=> ##1 $stable(zero_o)) else $error("swap changed the zero flag");
  AST_SWAP_DEST: assert property (tk && op6 == 6'h0e && opc_i[7]
    |=> ##1 $stable(acc_o)) else $error("swap to file changed acc");
  AST_XORL: assert property (tk && op6 == 6'h3a
    |=> ##1 acc_o == ($past(acc_o, 2) ^ $past(opc_i[7:0], 2)))
    else $error("literal xor result wrong");
  AST_ZERO: assert property (tk && op6 == 6'h3a
    |=> ##1 zero_o == (acc_o == 8'h00)) else $error("zero flag wrong");
  AST_DIRL: assert property (tk && opc_i == 14'h0065
    |=> ##1 dir5_o == $past(acc_o, 2) && $stable(zero_o))
    else $error("direction load wrong");
  AST_XORF_DEST: assert property (tk && op6 == 6'h06 && opc_i[7]
    |=> ##1 $stable(acc_o)) else $error("file xor to file changed acc");
endmodule // sxte_exec_chk
bind sxte_exec sxte_exec_chk u_chk (.ref_clk_i(ref_clk_i),
  .reset_n_i(reset_n_i), .opc_valid_i(opc_valid_i), .opc_i(opc_i),
  .busy_o(busy_o), .done_o(done_o), .acc_o(acc_o), .zero_o(zero_o),
  .dir5_o(dir5_o));
`default_nettype wire

// *** test/tb_swap_xor_direction_load_op_exec.sv ***
// random and corner-case bench for the execution block
`timescale 1ns/10ps
`default_nettype none
module tb_swap_xor_direction_load_op_exec;
  logic clk = 0, rst_n = 0, vld = 0, dbv = 0;
  logic [13:0] opc = 0;
  logic [6:0] dba = 0;
  wire busy, done, zero;
  wire [7:0] acc, d5, d6, d7, dbd;
  logic [7:0] m_acc = 0, r;
  logic [7:0] m_dir [5:7] = '{8'hff, 8'hff, 8'hff};
  logic [7:0] m_f [0:127];
  logic m_z = 0;
  logic [31:0] seed = 80;
  int n_fail = 0, tests_run = 0;
  sxte_exec i_dut (.ref_clk_i(clk), .reset_n_i(rst_n), .opc_valid_i(vld),
    .opc_i(opc), .busy_o(busy), .done_o(done), .acc_o(acc), .zero_o(zero),
    .dir5_o(d5), .dir6_o(d6), .dir7_o(d7), .dbg_rd_valid_i(dbv),
    .dbg_addr_i(dba), .dbg_data_o(dbd));
  initial forever #2 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // expected result of the swap and both xor opcodes, from the rules alone
  function automatic logic [7:0] calc(input logic [13:0] o,
    input logic [7:0] a, input logic [7:0] f);
    case (o[13:8])
      6'h0e: return {f[3:0], f[7:4]};
      6'h06: return a ^ f;
      default: return a ^ o[7:0];
    endcase
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic run_op(input logic [13:0] o);
    logic [7:0] f;
    vld <= 1'b1;
    opc <= o;
    @(posedge clk);
    // kept high through the busy edge: must be ignored
    @(posedge clk);
    vld <= 1'b0;
    f = m_f[o[6:0]];
    r = calc(o, m_acc, f);
    if (o[13:3] == 11'h00c && o[2:0] >= 3'h5) m_dir[o[2:0]] = m_acc;
    if (o[13:8] == 6'h0e || o[13:8] == 6'h06) begin
      if (o[7]) m_f[o[6:0]] = r;
      else m_acc = r;
    end
    if (o[13:8] == 6'h3a) m_acc = r;
    if (o[13:8] == 6'h3a || o[13:8] == 6'h06) m_z = (r == 8'h00);
    #1;
    cmp_flag(done, 1'b1);
    cmp(acc, m_acc);
    cmp_flag(zero, m_z);
    cmp(d5, m_dir[5]);
    cmp(d6, m_dir[6]);
    cmp(d7, m_dir[7]);
    @(posedge clk);
  endtask
  initial begin
    // the run needs about 1200 cycles; allow roughly four times that
    repeat (5000) @(posedge clk);
    n_fail++;
    test_done;
  end
  initial begin
    // file memory has no reset: seed it so every file result is known
    for (int k = 0; k < 128; k++) begin
      seed = xs(seed);
      m_f[k] = seed[7:0];
      i_dut.u_mem.mem[k] = seed[7:0];
    end
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    run_op(14'h3aaf);
    run_op(14'h3aaf);
    for (int i = 0; i < 8; i++) run_op(14'h0060 | i[13:0]);
    repeat (300) begin
      seed = xs(seed);
      case (seed[1:0])
        2'h0: run_op({6'h3a, seed[15:8]});
        2'h1: run_op({6'h0e, seed[16], seed[14:8]});
        2'h2: run_op({6'h06, seed[17], seed[14:8]});
        default: run_op({11'h00c, seed[10:8]});
      endcase
    end
    dbv <= 1'b1;
    for (int k = 0; k < 128; k++) begin
      dba <= k[6:0];
      @(posedge clk);
      #1;
      cmp(dbd, m_f[k]);
      @(posedge clk);
    end
    test_done;
  end
endmodule // tb_swap_xor_direction_load_op_exec
`default_nettype wire
